/* src/vpic_cfg.svh */
// register offsets, field positions, reset values for the interrupt controller
// assumes inclusion by the controller module, the testbench and the core model
`ifndef VPIC_CFG_SVH
`define VPIC_CFG_SVH
`define VPIC_ADDR_W 9
`define VPIC_OFF_SRC_CTRL_1 9'h000
`define VPIC_OFF_SRC_CTRL_8 9'h01c
`define VPIC_OFF_RAW 9'h100
`define VPIC_OFF_ACTIVE 9'h104
`define VPIC_OFF_MASKED 9'h108
`define VPIC_OFF_ENCODING 9'h10c
`define VPIC_OFF_SRCNUM 9'h110
`define VPIC_OFF_ENABLE 9'h114
`define VPIC_OFF_OUTLINE 9'h118
`define VPIC_OFF_EN_SET 9'h120
`define VPIC_OFF_EN_CLR 9'h124
`define VPIC_OFF_PEND_SET 9'h128
`define VPIC_OFF_PEND_CLR 9'h12c
`define VPIC_OFF_DONE 9'h130
`define VPIC_OFF_DEBUG 9'h134
`define VPIC_SRC_CTRL_RST 32'h4747_4747
`define VPIC_TYPE_EDGE_BIT 7
`define VPIC_TYPE_HIGH_BIT 6
`define VPIC_PRIO_LSB 0
`define VPIC_LEVEL_IDLE 4'h8
`endif

/* src/vpic_ctrl.sv */
// vectored priority interrupt controller, 32 channels, two output lines
// assumes synchronous source inputs and a single-cycle register port
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "vpic_cfg.svh"
// Overview of operation
// - two-bit type per channel: bit7 edge/level, bit6 high/low polarity
// - three-bit priority per channel, 0 most urgent, 7 least
// - winner at level 0 drives fast line, levels 1-7 normal line
// - equal levels: lower channel number wins
// - eight source-control words reset to high level, priority 7
// - raw status returns live input levels
// - active status follows type and polarity, ignores enable
// - masked status is active AND enable
// - encoding word shows winner times four in bits 6:2
// - winner number copied to five-bit source-number word
// - encoding word reads zero after a normal-mode read until new winner
// - enables gate arbitration and lines; reset to all disabled
// - output status: bit1 normal line, bit0 fast line
// - enable-set writes set enables where bits are one
// - enable-clear writes clear enables where bits are one
// - pending-set writes force channels active
// - pending-clear writes drop forced and latched edge requests
// - service-done pops last stacked priority level
// - encoding read pushes level, drops line, clears edge request
// - read with nothing pending returns zero, level unchanged
// - debug mode: push and acknowledge on encoding write instead
module vpic_ctrl
  import vpic_pkg::*;
#(
  parameter int NCH = 32
)
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [NCH-1:0] src_in,
  input wire logic [8:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic normal_int_line,
  output logic fast_int_line
);
  // ==========================================================
  // functions
  function automatic logic [3:0] lvl_of(input logic [2:0] p);
    lvl_of = {1'b0, p};
  endfunction

  // ==========================================================
  // storage
  logic [31:0] src_ctrl [8];
  logic [NCH-1:0] enable_bits;
  logic [NCH-1:0] edge_pend;
  logic [NCH-1:0] force_active_bits;
  logic [NCH-1:0] prev_in;
  logic [4:0] winner_id;
  logic [6:0] encoding;
  logic debug_mode;
  logic [3:0] cur_level;
  logic [3:0] stack [8];
  logic [3:0] sp;
  logic [4:0] held_id;
  logic [3:0] held_level;
  logic held_valid;
  vpic_bus_req_t req;
  vpic_chan_cfg_t cfg [NCH];

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      cfg[i].edge_sense = src_ctrl[i/4][8*(i%4)+`VPIC_TYPE_EDGE_BIT];
      cfg[i].high_active = src_ctrl[i/4][8*(i%4)+`VPIC_TYPE_HIGH_BIT];
      cfg[i].prio = src_ctrl[i/4][8*(i%4)+`VPIC_PRIO_LSB +: 3];
    end
  end

  // ==========================================================
  // active and arbitration
  logic [NCH-1:0] active_bits;
  logic [NCH-1:0] masked_pending_bits;
  logic [NCH-1:0] edge_hit;
  logic [4:0] next_win;
  logic [3:0] next_win_lvl;
  logic next_win_ok;

  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      edge_hit[i] = cfg[i].high_active ? (src_in[i] & ~prev_in[i])
                                       : (~src_in[i] & prev_in[i]);
      if (cfg[i].edge_sense)
        active_bits[i] = edge_pend[i] | force_active_bits[i];
      else
        active_bits[i] = (src_in[i] == cfg[i].high_active)
                         | force_active_bits[i];
    end
    masked_pending_bits = active_bits & enable_bits;
  end

  always_comb
  begin
    next_win = 5'h00;
    next_win_lvl = `VPIC_LEVEL_IDLE;
    next_win_ok = 1'b0;
    for (int i = NCH - 1; i >= 1; i--)
    begin
      if (masked_pending_bits[i] && lvl_of(cfg[i].prio) <= next_win_lvl)
      begin
        next_win = 5'(i);
        next_win_lvl = lvl_of(cfg[i].prio);
        next_win_ok = 1'b1;
      end
    end
    // only a request more urgent than the level in service preempts
    if (next_win_lvl >= cur_level)
      next_win_ok = 1'b0;
  end

  logic enc_read;
  logic enc_write;
  logic done_write;
  logic ack;
  logic [4:0] ack_id;
  logic [3:0] ack_lvl;
  logic ack_ok;
  assign enc_read = req.rd && req.addr == `VPIC_OFF_ENCODING;
  assign enc_write = req.wr && req.addr == `VPIC_OFF_ENCODING;
  assign done_write = req.wr && req.addr == `VPIC_OFF_DONE;
  // normal mode acknowledges on read, debug mode on write
  assign ack = debug_mode ? (enc_write && held_valid)
                          : (enc_read && encoding != 7'h00);
  assign ack_id = debug_mode ? held_id : encoding[6:2];
  assign ack_lvl = debug_mode ? held_level : lvl_of(cfg[encoding[6:2]].prio);
  assign ack_ok = ack && ack_id != 5'h00;

  // ==========================================================
  // registers
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      for (int k = 0; k < 8; k++)
        src_ctrl[k] <= `VPIC_SRC_CTRL_RST;
    else if (clk_en && req.wr && req.addr <= `VPIC_OFF_SRC_CTRL_8
             && req.addr[1:0] == 2'b00)
      src_ctrl[req.addr[4:2]] <= req.wdata;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      enable_bits <= '0;
    else if (clk_en && req.wr && req.addr == `VPIC_OFF_EN_SET)
      enable_bits <= enable_bits | req.wdata[NCH-1:0];
    else if (clk_en && req.wr && req.addr == `VPIC_OFF_EN_CLR)
      enable_bits <= enable_bits & ~req.wdata[NCH-1:0];
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      debug_mode <= 1'b0;
    else if (clk_en && req.wr && req.addr == `VPIC_OFF_DEBUG)
      debug_mode <= req.wdata[0];
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      prev_in <= '0;
    else if (clk_en)
      prev_in <= src_in;
  end

  // edge latch: new edge beats a clear in the same cycle
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      edge_pend <= '0;
    else if (clk_en)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        if (cfg[i].edge_sense && edge_hit[i])
          edge_pend[i] <= 1'b1;
        else if (ack_ok && ack_id == 5'(i))
          edge_pend[i] <= 1'b0;
        else if (req.wr && req.addr == `VPIC_OFF_PEND_CLR && req.wdata[i])
          edge_pend[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      force_active_bits <= '0;
    else if (clk_en)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        if (req.wr && req.addr == `VPIC_OFF_PEND_SET && req.wdata[i])
          force_active_bits[i] <= 1'b1;
        else if (req.wr && req.addr == `VPIC_OFF_PEND_CLR && req.wdata[i])
          force_active_bits[i] <= 1'b0;
        else if (ack_ok && ack_id == 5'(i))
          force_active_bits[i] <= 1'b0;
      end
    end
  end

  // debug mode snapshot taken at each encoding read
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      held_id <= 5'h00;
      held_level <= `VPIC_LEVEL_IDLE;
      held_valid <= 1'b0;
    end
    else if (clk_en && debug_mode)
    begin
      if (enc_read)
      begin
        held_id <= encoding[6:2];
        held_level <= lvl_of(cfg[encoding[6:2]].prio);
        held_valid <= encoding != 7'h00;
      end
      else if (enc_write)
        held_valid <= 1'b0;
    end
  end

  // priority stack
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      cur_level <= `VPIC_LEVEL_IDLE;
      sp <= 4'h0;
      for (int k = 0; k < 8; k++)
        stack[k] <= `VPIC_LEVEL_IDLE;
    end
    else if (clk_en)
    begin
      if (ack_ok && sp < 4'h8)
      begin
        stack[sp[2:0]] <= cur_level;
        sp <= sp + 4'h1;
        cur_level <= ack_lvl;
      end
      else if (done_write && sp != 4'h0)
      begin
        cur_level <= stack[sp[2:0] - 3'h1];
        sp <= sp - 4'h1;
      end
    end
  end

  // winner encoding and source number
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      encoding <= 7'h00;
      winner_id <= 5'h00;
    end
    else if (clk_en)
    begin
      if (enc_read)
        encoding <= 7'h00;
      else
        encoding <= next_win_ok ? {next_win, 2'b00} : 7'h00;
      if (ack_ok)
        winner_id <= ack_id;
      else if (next_win_ok && !debug_mode)
        winner_id <= next_win;
    end
  end

  // output lines: held low after an acknowledge until a higher request
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      normal_int_line <= 1'b0;
      fast_int_line <= 1'b0;
    end
    else if (clk_en)
    begin
      normal_int_line <= next_win_ok && next_win_lvl != 4'h0
                         && !ack;
      fast_int_line <= next_win_ok && next_win_lvl == 4'h0 && !ack;
    end
  end

  // ==========================================================
  // read port
  logic [31:0] next_rdata;
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (req.addr <= `VPIC_OFF_SRC_CTRL_8 && req.addr[1:0] == 2'b00)
      next_rdata = src_ctrl[req.addr[4:2]] & 32'hc7c7_c7c7;
    else
      case (req.addr)
        `VPIC_OFF_RAW: next_rdata = 32'(src_in);
        `VPIC_OFF_ACTIVE: next_rdata = 32'(active_bits);
        `VPIC_OFF_MASKED: next_rdata = 32'(masked_pending_bits);
        `VPIC_OFF_ENCODING: next_rdata = {25'h0, encoding};
        `VPIC_OFF_SRCNUM: next_rdata = {27'h0, winner_id};
        `VPIC_OFF_ENABLE: next_rdata = 32'(enable_bits);
        `VPIC_OFF_OUTLINE:
          next_rdata = {30'h0, normal_int_line, fast_int_line};
        `VPIC_OFF_DEBUG: next_rdata = {31'h0, debug_mode};
        default: next_rdata = 32'h0000_0000;
      endcase
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 32'h0000_0000;
    else if (clk_en && req.rd)
      reg_rdata <= next_rdata;
  end

  // ==========================================================
  // checks
  AST_FAST_LVL0: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && next_win_ok && next_win_lvl == 4'h0 && !ack
    |=> fast_int_line) else $error("fast line missing");
  AST_NORM_LVL: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && next_win_ok && next_win_lvl != 4'h0 && !ack
    |=> normal_int_line && !fast_int_line)
    else $error("normal line wrong");
  AST_EXCL: assert property (@(posedge clock) disable iff (!resetn)
    !(normal_int_line && fast_int_line))
    else $error("both lines high");
  AST_NO_CH0: assert property (@(posedge clock) disable iff (!resetn)
    next_win_ok |-> next_win != 5'h00) else $error("channel 0 won");
  AST_MASKED: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && req.rd && req.addr == `VPIC_OFF_MASKED
    |=> reg_rdata == 32'($past(active_bits & enable_bits)))
    else $error("masked read wrong");
  AST_EN_SET: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && req.wr && req.addr == `VPIC_OFF_EN_SET
    |=> (enable_bits & $past(req.wdata)) == $past(req.wdata))
    else $error("enable set lost");
  AST_EN_CLR: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && req.wr && req.addr == `VPIC_OFF_EN_CLR
    |=> (enable_bits & $past(req.wdata)) == 32'h0)
    else $error("enable clear lost");
  AST_ENC_ZERO: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && enc_read |=> encoding == 7'h00)
    else $error("encoding not cleared");
  AST_POP: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && done_write && !ack_ok && sp != 4'h0
    |=> cur_level == $past(stack[sp[2:0] - 3'h1]))
    else $error("pop wrong");
  AST_FAKE: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && enc_read && !debug_mode && encoding == 7'h00 && !done_write
    |=> $stable(cur_level)) else $error("level moved");
  COV_FAST: cover property (@(posedge clock) fast_int_line);
  COV_NEST: cover property (@(posedge clock) sp == 4'h2);
  COV_DEBUG_ACK: cover property (@(posedge clock) debug_mode && ack_ok);
endmodule

/* src/vpic_pkg.sv */
// types shared by the interrupt controller
// assumes the cfg header beside it
package vpic_pkg;
  typedef struct packed
  {
    logic edge_sense;
    logic high_active;
    logic [2:0] prio;
  } vpic_chan_cfg_t;
  typedef struct packed
  {
    logic [8:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } vpic_bus_req_t;
endpackage

/* verification/testbench.sv */
// self-checking bench for the interrupt controller
// assumes the package, offsets header and core stand-in
`timescale 1ns/1ps
`include "vpic_cfg.svh"
module testbench
  import vpic_pkg::*;
;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [31:0] src = 32'h0;
  logic serve = 1'b0;
  logic clk_en = 1'b1;
  logic [2:0] lat = 3'h0;
  vpic_bus_req_t breq = '0;
  vpic_bus_req_t creq;
  vpic_bus_req_t req;
  logic [31:0] reg_rdata;
  logic normal_int_line;
  logic fast_int_line;
  logic [31:0] last_vec;
  logic [7:0] n_served;
  int n_fail = 0;
  int total_checks = 0;
  logic [31:0] ctrl_m [8];
  logic [31:0] en_m = 32'h0;
  logic [31:0] act_m = 32'h0;
  int cur = 8;
  int stk [$];
  assign req = serve ? creq : breq;
  always #2 clock = ~clock;
  vpic_ctrl #(.NCH(32)) u_vpic_ctrl (
    .clock(clock), .resetn(resetn), .clk_en(clk_en), .src_in(src),
    .reg_addr(req.addr), .reg_wdata(req.wdata), .reg_wr(req.wr),
    .reg_rd(req.rd), .reg_rdata(reg_rdata),
    .normal_int_line(normal_int_line), .fast_int_line(fast_int_line)
  );
  vpic_core_model u_vpic_core_model (
    .clock(clock), .resetn(resetn), .serve(serve), .lat(lat),
    .normal_int_line(normal_int_line), .fast_int_line(fast_int_line),
    .reg_rdata(reg_rdata), .req(creq), .last_vec(last_vec),
    .n_served(n_served)
  );
  // ==========
  // bus tasks and reference model
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge clock);
    breq <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    breq.wr <= 1'b0;
    #1;
    if (a < 9'h020 && a[1:0] == 2'b00)
      ctrl_m[a[4:2]] = d & 32'hc7c7_c7c7;
    if (a == `VPIC_OFF_EN_SET)
      en_m = en_m | d;
    if (a == `VPIC_OFF_EN_CLR)
      en_m = en_m & ~d;
  endtask
  task automatic rd(input logic [8:0] a, output logic [31:0] d);
    @(posedge clock);
    breq <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clock);
    breq.rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic rc(input logic [8:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  task automatic put(input logic [31:0] v);
    @(posedge clock);
    src <= v;
    act_m = v;
    repeat (3) @(posedge clock);
    #1;
  endtask
  function automatic int pr(input int c);
    return int'(ctrl_m[c / 4][8 * (c % 4) +: 3]);
  endfunction
  function automatic int win();
    int w = 0;
    for (int c = 1; c < 32; c++)
      if (act_m[c] && en_m[c] && pr(c) < cur && (w == 0 || pr(c) < pr(w)))
        w = c;
    return w;
  endfunction
  task automatic lines();
    int w;
    logic [1:0] e;
    w = win();
    e = {w != 0 && pr(w) != 0, w != 0 && pr(w) == 0};
    for (int k = 0; k < 8 && {normal_int_line, fast_int_line} !== e; k++)
    begin
      @(posedge clock);
      #1;
    end
    chk(32'({normal_int_line, fast_int_line}), 32'(e));
  endtask
  task automatic ack();
    int w;
    logic [31:0] d;
    w = win();
    rd(`VPIC_OFF_ENCODING, d);
    chk(d, 32'(w * 4));
    if (w != 0)
    begin
      stk.push_back(cur);
      cur = pr(w);
      rc(`VPIC_OFF_SRCNUM, 32'(w));
    end
  endtask
  task automatic done();
    wr(`VPIC_OFF_DONE, $urandom);
    if (stk.size() > 0)
      cur = stk.pop_back();
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #40000;
    n_fail++;
    end_sim();
  end
  // ==========
  // test sequence
  initial
  begin
    logic [31:0] r;
    logic [31:0] e1;
    logic [31:0] e2;
    for (int i = 0; i < 8; i++)
      ctrl_m[i] = `VPIC_SRC_CTRL_RST;
    void'($urandom(32'hc4ed4994));
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    for (int i = 0; i < 8; i++)
      rc(9'(i * 4), 32'h4747_4747);
    wr(`VPIC_OFF_ENABLE, 32'hffff_ffff);
    rc(`VPIC_OFF_ENABLE, 32'h0);
    @(posedge clock);
    clk_en <= 1'b0;
    wr(`VPIC_OFF_EN_SET, 32'hffff_ffff);
    @(posedge clock);
    clk_en <= 1'b1;
    en_m = 32'h0;
    rc(`VPIC_OFF_ENABLE, 32'h0);
    rc(`VPIC_OFF_ENCODING, 32'h0);
    rc(`VPIC_OFF_OUTLINE, 32'h0);
    rc(`VPIC_OFF_EN_SET, 32'h0);
    rc(9'h1f0, 32'h0);
    $display("test reset done");
    repeat (4)
    begin
      r = $urandom;
      e1 = $urandom;
      e2 = $urandom;
      put(r);
      wr(`VPIC_OFF_EN_SET, e1);
      wr(`VPIC_OFF_EN_CLR, e2);
      rc(`VPIC_OFF_RAW, r);
      rc(`VPIC_OFF_ACTIVE, r);
      rc(`VPIC_OFF_MASKED, r & en_m);
      rc(`VPIC_OFF_ENABLE, en_m);
    end
    wr(`VPIC_OFF_EN_CLR, 32'hffff_ffff);
    $display("test status words done");
    put(32'h0);
    wr(9'h004, 32'hc787_4707);
    wr(`VPIC_OFF_PEND_CLR, 32'h0000_00c0);
    rc(9'h004, 32'hc787_4707);
    rc(`VPIC_OFF_ACTIVE, 32'h10);
    put(32'hf0);
    rc(`VPIC_OFF_ACTIVE, 32'ha0);
    put(32'h0);
    rc(`VPIC_OFF_ACTIVE, 32'hd0);
    wr(`VPIC_OFF_PEND_CLR, 32'h0000_00c0);
    rc(`VPIC_OFF_ACTIVE, 32'h10);
    wr(`VPIC_OFF_PEND_SET, 32'h0000_0040);
    rc(`VPIC_OFF_ACTIVE, 32'h50);
    wr(`VPIC_OFF_PEND_CLR, 32'h0000_0040);
    $display("test trigger modes done");
    wr(9'h008, 32'h4041_4343);
    wr(9'h000, 32'h4747_4740);
    wr(`VPIC_OFF_EN_SET, 32'h0000_0f01);
    put(32'h301);
    lines();
    rc(`VPIC_OFF_OUTLINE, 32'h2);
    rc(`VPIC_OFF_MASKED, 32'h301);
    ack();
    ack();
    lines();
    put(32'h701);
    lines();
    ack();
    put(32'hf01);
    lines();
    rc(`VPIC_OFF_OUTLINE, 32'h1);
    ack();
    put(32'h301);
    done();
    lines();
    done();
    lines();
    done();
    lines();
    ack();
    wr(`VPIC_OFF_EN_CLR, 32'h0000_0f01);
    ack();
    lines();
    done();
    $display("test arbitration done");
    wr(`VPIC_OFF_EN_SET, 32'h0000_0080);
    put(32'h80);
    lines();
    @(posedge clock);
    lat <= 3'($urandom % 8);
    serve <= 1'b1;
    for (int k = 0; k < 40 && n_served == 8'h0; k++)
      @(posedge clock);
    serve <= 1'b0;
    chk(last_vec, 32'h1c);
    act_m = 32'h0;
    lines();
    rc(`VPIC_OFF_ACTIVE, 32'h10);
    $display("test core service done");
    wr(`VPIC_OFF_DEBUG, 32'h1);
    rc(`VPIC_OFF_DEBUG, 32'h1);
    wr(`VPIC_OFF_EN_SET, 32'h0000_0400);
    put(32'h400);
    lines();
    rc(`VPIC_OFF_ENCODING, 32'h28);
    lines();
    wr(`VPIC_OFF_ENCODING, $urandom);
    stk.push_back(cur);
    cur = pr(10);
    lines();
    rc(`VPIC_OFF_SRCNUM, 32'ha);
    done();
    lines();
    wr(`VPIC_OFF_EN_CLR, 32'hffff_ffff);
    wr(`VPIC_OFF_DEBUG, 32'h0);
    $display("test debug mode done");
    end_sim();
  end
endmodule

/* verification/vpic_core_model.sv */
// processor core stand-in: serves an asserted interrupt line
// assumes the controller's one-cycle register port and offsets header
`timescale 1ns/1ps
`include "vpic_cfg.svh"
module vpic_core_model
  import vpic_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic serve,
  input wire logic [2:0] lat,
  input wire logic normal_int_line,
  input wire logic fast_int_line,
  input wire logic [31:0] reg_rdata,
  output vpic_bus_req_t req,
  output logic [31:0] last_vec,
  output logic [7:0] n_served
);
  // ==========
  // handler: wait lat cycles, read encoding, end of service
  logic [2:0] st;
  logic [2:0] cnt;
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      st <= 3'h0;
      cnt <= 3'h0;
      req <= '0;
      last_vec <= 32'h0;
      n_served <= 8'h0;
    end
    else
    begin
      req.rd <= 1'b0;
      req.wr <= 1'b0;
      cnt <= (st == 3'h0) ? 3'h0 : cnt + 3'h1;
      case (st)
        3'h0: if (serve && (normal_int_line || fast_int_line))
          st <= 3'h1;
        3'h1: if (cnt == lat)
        begin
          req <= '{`VPIC_OFF_ENCODING, 32'h0, 1'b0, 1'b1};
          st <= 3'h2;
        end
        3'h2: st <= 3'h3;
        3'h3:
        begin
          last_vec <= reg_rdata;
          req <= '{`VPIC_OFF_DONE, 32'h0, 1'b1, 1'b0};
          st <= 3'h4;
        end
        default:
        begin
          n_served <= n_served + 8'h1;
          st <= 3'h0;
        end
      endcase
    end
  end
endmodule
